/* File: alu_pkg.sv */
// constants, opcodes and field layout for the fixed/float alu slice
package alu_pkg;

  localparam int unsigned WORD_W = 40;
  localparam int unsigned FIX_W  = 32;
  localparam int unsigned FIX_LO = 8;

  localparam logic [11:0] CTRL_OFFSET   = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;

  localparam int unsigned CTRL_SAT_BIT   = 0;
  localparam int unsigned CTRL_TRUNC_BIT = 1;
  localparam int unsigned CTRL_RND32_BIT = 2;
  localparam logic [2:0]  CTRL_RESET     = 3'h0;

  localparam int unsigned FLAG_ZERO   = 0;
  localparam int unsigned FLAG_UNDER  = 1;
  localparam int unsigned FLAG_NEG    = 2;
  localparam int unsigned FLAG_OVER   = 3;
  localparam int unsigned FLAG_CARRY  = 4;
  localparam int unsigned FLAG_INSIGN = 5;
  localparam int unsigned FLAG_INVAL  = 6;
  localparam logic [6:0]  FLAGS_RESET = 7'h00;

  localparam logic [31:0] FIX_MOST_NEG = 32'h8000_0000;
  localparam logic [31:0] FIX_MOST_POS = 32'h7FFF_FFFF;
  localparam logic [31:0] FIX_ONES     = 32'hFFFF_FFFF;
  localparam logic [7:0]  EXP_SPECIAL  = 8'hFF;
  localparam logic [7:0]  EXP_LARGEST_NORMAL_MAGNITUDE = 8'hFE;
  localparam logic [10:0] EXP_BIAS_MAX = 11'h0FE;
  localparam logic [31:0] RND32_STEP   = 32'h0000_0100;
  localparam logic [30:0] RND32_MASK   = 31'h7FFF_FF00;

  typedef enum logic [3:0] {
    OP_DEC  = 4'b0000,
    OP_NEG  = 4'b0001,
    OP_ABS  = 4'b0010,
    OP_PASS = 4'b0011,
    OP_AND  = 4'b0100,
    OP_OR   = 4'b0101,
    OP_XOR  = 4'b0110,
    OP_NOT  = 4'b0111,
    OP_MIN  = 4'b1000,
    OP_MAX  = 4'b1001,
    OP_CLIP = 4'b1010,
    OP_FADD = 4'b1011,
    OP_FSUB = 4'b1100
  } alu_op_t;

endpackage

/* File: fixed_float_alu_ops.sv */
// alu slice: fixed-point ops, float add/subtract, flags, apb control
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module fixed_float_alu_ops (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        op_valid,
  input  wire logic [3:0]  op_code,
  input  wire logic [39:0] x_operand,
  input  wire logic [39:0] y_operand,
  output logic             result_valid,
  output logic      [39:0] result,
  output logic             alu_zero_flag,
  output logic             alu_underflow_flag,
  output logic             alu_negative_flag,
  output logic             alu_overflow_flag,
  output logic             alu_carry_flag,
  output logic             alu_input_sign_flag,
  output logic             alu_invalid_flag
);

  logic [2:0]  core_control_register;
  logic [6:0]  arith_status_register;
  logic [39:0] next_result;
  logic [6:0]  next_flags;
  logic        op_known;

  // returns {carry out, carry into msb, sum}
  function automatic logic [33:0] add32(input logic [31:0] a,
                                        input logic [31:0] b,
                                        input logic        cin);
    logic [32:0] full;
    logic [31:0] low;
    full = {1'b0, a} + {1'b0, b} + {32'h0000_0000, cin};
    low  = {1'b0, a[30:0]} + {1'b0, b[30:0]} + {31'h0000_0000, cin};
    return {full[32], low[31], full[31:0]};
  endfunction

  // counts down from the msb; the first set bit stops the count
  function automatic logic [5:0] lead_zeros(input logic [56:0] v);
    logic [5:0] n;
    logic       hit;
    n = 6'd0;
    hit = 1'b0;
    for (int i = 56; i >= 0; i--) begin
      if (!hit && v[i]) begin
        hit = 1'b1;
      end else if (!hit) begin
        n = n + 6'd1;
      end
    end
    return n;
  endfunction

  // ---------------- fixed-point path ----------------
  logic [31:0] fx;
  logic [31:0] fy;
  logic [33:0] dec_sum;
  logic [33:0] neg_sum;
  logic [33:0] abs_sum;
  logic [32:0] mag_x;
  logic [32:0] mag_y;
  logic [31:0] abs_y;
  logic [31:0] fix_res;
  logic        sat;

  assign fx  = x_operand[39:8];
  assign fy  = y_operand[39:8];
  assign sat = core_control_register[alu_pkg::CTRL_SAT_BIT];

  // every adder runs each cycle; the opcode only picks a sum
  always_comb begin
    dec_sum = add32(fx, alu_pkg::FIX_ONES, 1'b0);
    neg_sum = add32(~fx, 32'h0000_0000, 1'b1);
    abs_sum = fx[31] ? neg_sum : add32(fx, 32'h0000_0000, 1'b0);
    mag_x   = fx[31] ? ({1'b0, ~fx} + 33'h0_0000_0001) : {1'b0, fx};
    mag_y   = fy[31] ? ({1'b0, ~fy} + 33'h0_0000_0001) : {1'b0, fy};
    abs_y   = mag_y[31:0];
  end

  // result select; the flags further down reuse the same carries
  always_comb begin
    fix_res   = fx;
    case (op_code)
      alu_pkg::OP_DEC: begin
        // borrow past most negative: overflow bit from the adder
        // saturation only swaps the value; overflow and carry still report
        fix_res = (sat && (dec_sum[33] ^ dec_sum[32])) ? alu_pkg::FIX_MOST_NEG
                                                      : dec_sum[31:0];
      end
      alu_pkg::OP_NEG: begin
        fix_res = (sat && (neg_sum[33] ^ neg_sum[32])) ? alu_pkg::FIX_MOST_POS
                                                      : neg_sum[31:0];
      end
      alu_pkg::OP_ABS: begin
        fix_res = (sat && (abs_sum[33] ^ abs_sum[32])) ? alu_pkg::FIX_MOST_POS
                                                      : abs_sum[31:0];
      end
      alu_pkg::OP_PASS: fix_res = fx;
      alu_pkg::OP_AND:  fix_res = fx & fy;
      alu_pkg::OP_OR:   fix_res = fx | fy;
      alu_pkg::OP_XOR:  fix_res = fx ^ fy;
      alu_pkg::OP_NOT:  fix_res = ~fx;
      alu_pkg::OP_MIN:  fix_res = ($signed(fx) < $signed(fy)) ? fx : fy;
      alu_pkg::OP_MAX:  fix_res = ($signed(fx) > $signed(fy)) ? fx : fy;
      alu_pkg::OP_CLIP: begin
        // magnitudes compared unsigned at 33 bits so most negative is not lost
        if (mag_x < mag_y) begin
          fix_res = fx;
        end else begin
          fix_res = fx[31] ? (~abs_y + 32'h0000_0001) : abs_y;
        end
      end
      default: fix_res = fx;
    endcase
  end

  // ---------------- floating-point path ----------------
  logic        is_sub;
  logic        sx;
  logic        sy;
  logic [7:0]  ex;
  logic [7:0]  ey;
  logic [30:0] mx;
  logic [30:0] my;
  logic        nan_in;
  logic        inf_x;
  logic        inf_y;
  logic        x_big;
  logic        s_big;
  logic [7:0]  e_big;
  logic [7:0]  diff;
  logic [55:0] sig_x;
  logic [55:0] sig_y;
  logic [55:0] sig_big;
  logic [55:0] sig_small;
  logic [55:0] aligned;
  logic        align_sticky;
  logic [56:0] raw_sum;
  logic [5:0]  lz;
  logic [56:0] norm;
  logic        trunc;
  logic        rnd32;
  logic        guard;
  logic        lsb;
  logic        sticky;
  logic        inc;
  logic [30:0] m_kept;
  logic [31:0] m_round;
  logic [10:0] e_fin;
  logic        f_ovf;
  logic        f_den;
  logic        f_zero;
  logic        f_sign;
  logic [39:0] f_res;
  logic [6:0]  f_flags;

  assign trunc = core_control_register[alu_pkg::CTRL_TRUNC_BIT];
  assign rnd32 = core_control_register[alu_pkg::CTRL_RND32_BIT];

  // subtract is an add with the second sign flipped
  always_comb begin
    is_sub = (op_code == alu_pkg::OP_FSUB);
    sx = x_operand[39];
    sy = y_operand[39] ^ is_sub;
    ex = x_operand[38:31];
    ey = y_operand[38:31];
    // exponent zero means denormal or zero: flushed to signed zero
    mx = (ex == 8'h00) ? 31'h0000_0000 : x_operand[30:0];
    my = (ey == 8'h00) ? 31'h0000_0000 : y_operand[30:0];
    nan_in = ((ex == alu_pkg::EXP_SPECIAL) && (mx != 31'h0000_0000)) ||
             ((ey == alu_pkg::EXP_SPECIAL) && (my != 31'h0000_0000));
    inf_x = (ex == alu_pkg::EXP_SPECIAL) && (mx == 31'h0000_0000);
    inf_y = (ey == alu_pkg::EXP_SPECIAL) && (my == 31'h0000_0000);
    sig_x = {(ex != 8'h00), mx, 24'h00_0000};
    sig_y = {(ey != 8'h00), my, 24'h00_0000};
    // larger magnitude first, so the significand subtract never goes negative
    x_big = {ex, mx} >= {ey, my};
    s_big     = x_big ? sx : sy;
    e_big     = x_big ? ex : ey;
    sig_big   = x_big ? sig_x : sig_y;
    sig_small = x_big ? sig_y : sig_x;
    diff      = x_big ? (ex - ey) : (ey - ex);
    // a shift past the width leaves only the sticky bit
    if (diff > 8'd55) begin
      aligned      = 56'h0;
      align_sticky = |sig_small;
    end else begin
      aligned      = sig_small >> diff;
      align_sticky = |(sig_small & ~({56{1'b1}} << diff));
    end
    if (sx ^ sy) begin
      raw_sum = {1'b0, sig_big} - {1'b0, aligned};
    end else begin
      raw_sum = {1'b0, sig_big} + {1'b0, aligned};
    end
  end

  // normalise, then round at the selected boundary
  always_comb begin
    lz   = lead_zeros(raw_sum);
    norm = raw_sum << lz;
    m_kept = norm[55:25];
    // round point at bit 8 of the mantissa for the short boundary
    if (rnd32) begin
      m_kept = norm[55:25] & alu_pkg::RND32_MASK;
      guard  = norm[32];
      lsb    = norm[33];
      sticky = (|norm[31:0]) | align_sticky;
    end else begin
      guard  = norm[24];
      lsb    = norm[25];
      sticky = (|norm[23:0]) | align_sticky;
    end
    // nearest is ties-to-even: the kept lsb breaks a tie
    inc = !trunc && guard && (sticky || lsb);
    m_round = {1'b0, m_kept} +
              (inc ? (rnd32 ? alu_pkg::RND32_STEP : 32'h0000_0001) : 32'h0000_0000);
    e_fin = {3'b000, e_big} + 11'd1 - {5'b00000, lz} + {10'h000, m_round[31]};
    f_zero = (raw_sum == 57'h0);
    f_ovf  = !f_zero && !e_fin[10] && (e_fin > alu_pkg::EXP_BIAS_MAX);
    f_den  = !f_zero && (e_fin[10] || (e_fin == 11'h000));
    // exact cancellation yields plus zero unless both signs are negative after the subtract flip
    f_sign = f_zero ? (sx & sy) : s_big;
  end

  // specials first: nan, then infinities, then range checks
  always_comb begin
    f_flags = 7'h00;
    if (nan_in || (inf_x && inf_y && (sx != sy))) begin
      f_res = {40{1'b1}};
      f_flags[alu_pkg::FLAG_INVAL] = 1'b1;
    end else if (inf_x || inf_y) begin
      f_res = {(inf_x ? sx : sy), alu_pkg::EXP_SPECIAL, 31'h0000_0000};
      f_flags[alu_pkg::FLAG_NEG] = inf_x ? sx : sy;
    end else if (f_ovf) begin
      f_res = trunc ? {f_sign, alu_pkg::EXP_LARGEST_NORMAL_MAGNITUDE, {31{1'b1}}}
                    : {f_sign, alu_pkg::EXP_SPECIAL, 31'h0000_0000};
      f_flags[alu_pkg::FLAG_OVER] = 1'b1;
      f_flags[alu_pkg::FLAG_NEG]  = f_sign;
    end else if (f_zero || f_den) begin
      f_res = {f_sign, 39'h0};
      f_flags[alu_pkg::FLAG_ZERO]  = 1'b1;
      f_flags[alu_pkg::FLAG_UNDER] = f_den;
      f_flags[alu_pkg::FLAG_NEG]   = f_sign;
    end else begin
      f_res = {f_sign, e_fin[7:0], m_round[30:0]};
      f_flags[alu_pkg::FLAG_NEG] = f_sign;
    end
  end

  // ---------------- result and flag selection ----------------
  logic [39:0] fix_word;

  always_comb begin
    op_known   = 1'b1;
    fix_word   = {fix_res, 8'h00};
    next_result = fix_word;
    next_flags  = 7'h00;
    next_flags[alu_pkg::FLAG_ZERO] = (fix_res == 32'h0000_0000);
    next_flags[alu_pkg::FLAG_NEG]  = fix_res[31];
    case (op_code)
      alu_pkg::OP_DEC: begin
        next_flags[alu_pkg::FLAG_OVER]  = dec_sum[33] ^ dec_sum[32];
        next_flags[alu_pkg::FLAG_CARRY] = dec_sum[33];
      end
      alu_pkg::OP_NEG: begin
        next_flags[alu_pkg::FLAG_OVER]  = neg_sum[33] ^ neg_sum[32];
        next_flags[alu_pkg::FLAG_CARRY] = neg_sum[33];
      end
      alu_pkg::OP_ABS: begin
        next_flags[alu_pkg::FLAG_OVER]   = abs_sum[33] ^ abs_sum[32];
        next_flags[alu_pkg::FLAG_CARRY]  = abs_sum[33];
        next_flags[alu_pkg::FLAG_INSIGN] = fx[31];
      end
      alu_pkg::OP_PASS, alu_pkg::OP_AND, alu_pkg::OP_OR, alu_pkg::OP_XOR,
      alu_pkg::OP_NOT, alu_pkg::OP_MIN, alu_pkg::OP_MAX, alu_pkg::OP_CLIP: begin
        // no add32 sum involved: no arithmetic events to report
        next_flags[alu_pkg::FLAG_OVER]   = 1'b0;
        next_flags[alu_pkg::FLAG_CARRY]  = 1'b0;
        next_flags[alu_pkg::FLAG_INSIGN] = 1'b0;
      end
      alu_pkg::OP_FADD, alu_pkg::OP_FSUB: begin
        next_result = f_res;
        next_flags  = f_flags;
      end
      default: begin
        // unknown codes leave result and flags untouched
        op_known = 1'b0;
      end
    endcase
  end

  // result and all seven flags land on the same edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result                <= 40'h00_0000_0000;
      arith_status_register <= alu_pkg::FLAGS_RESET;
    end else if (op_valid && op_known) begin
      result                <= next_result;
      arith_status_register <= next_flags;
    end
  end

  // one pulse per accepted op; stays high across back-to-back ops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_valid <= 1'b0;
    end else begin
      result_valid <= op_valid && op_known;
    end
  end

  // each flag port is one bit of the status register
  assign alu_zero_flag       = arith_status_register[alu_pkg::FLAG_ZERO];
  assign alu_underflow_flag  = arith_status_register[alu_pkg::FLAG_UNDER];
  assign alu_negative_flag   = arith_status_register[alu_pkg::FLAG_NEG];
  assign alu_overflow_flag   = arith_status_register[alu_pkg::FLAG_OVER];
  assign alu_carry_flag      = arith_status_register[alu_pkg::FLAG_CARRY];
  assign alu_input_sign_flag = arith_status_register[alu_pkg::FLAG_INSIGN];
  assign alu_invalid_flag    = arith_status_register[alu_pkg::FLAG_INVAL];

  // ---------------- apb slave ----------------
  logic        setup;
  logic        access;
  logic        hit_ctrl;
  logic        hit_status;
  logic [31:0] next_prdata;

  assign setup      = psel && !penable;
  assign access     = psel && penable;
  assign hit_ctrl   = (paddr == alu_pkg::CTRL_OFFSET);
  assign hit_status = (paddr == alu_pkg::STATUS_OFFSET);
  // no wait states: every register answers in the access cycle
  assign pready     = 1'b1;
  assign pslverr    = access && !(hit_ctrl || hit_status);

  // unmapped reads return zero rather than stale data
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (hit_ctrl) begin
      next_prdata = {29'h0000_0000, core_control_register};
    end else if (hit_status) begin
      next_prdata = {25'h000_0000, arith_status_register};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_control_register <= alu_pkg::CTRL_RESET;
    // only the low three bits exist; the rest read back zero
    end else if (access && pwrite && hit_ctrl) begin
      core_control_register <= pwdata[2:0];
    end
  end

  // read data captured in setup so the access phase shows a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= next_prdata;
    end
  end

endmodule

/* File: alu_ops_props.sv */
// concurrent checks on the alu slice ports
`timescale 1ns/1ps
module alu_ops_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        op_valid,
  input wire logic [3:0]  op_code,
  input wire logic [39:0] x_operand,
  input wire logic        result_valid,
  input wire logic [39:0] result,
  input wire logic        alu_zero_flag,
  input wire logic        alu_underflow_flag,
  input wire logic        alu_negative_flag,
  input wire logic        alu_overflow_flag,
  input wire logic        alu_carry_flag,
  input wire logic        alu_input_sign_flag,
  input wire logic        alu_invalid_flag
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire legal = op_valid && op_code <= 4'hC;
  wire fixed = op_valid && op_code <= 4'hA;
  wire flt   = op_valid && (op_code == 4'hB || op_code == 4'hC);
  wire nan_x = x_operand[38:31] == 8'hFF && x_operand[30:0] != 31'h0;
  accept_strobe_a: assert property (legal |=> result_valid)
    else $error("accepted op gave no strobe");
  refuse_hold_a: assert property (!legal |=> !result_valid && $stable(result))
    else $error("refused op changed the result");
  ext_clear_a: assert property (fixed |=> result[7:0] == 8'h00)
    else $error("extension field not zero");
  sign_flag_a: assert property (legal |=> alu_input_sign_flag ==
    ($past(op_code) == 4'h2 && $past(x_operand[39]))) else $error("input sign flag wrong");
  fix_flags_a: assert property (fixed |=> alu_zero_flag == (result[39:8] == 32'h0) &&
    alu_negative_flag == result[39] && !alu_underflow_flag && !alu_invalid_flag)
    else $error("fixed flags wrong");
  logic_clear_a: assert property (op_valid && op_code inside {[4'h3:4'h9]} |=>
    !alu_overflow_flag && !alu_carry_flag) else $error("overflow or carry not cleared");
  pass_copy_a: assert property (op_valid && op_code == 4'h3 |=>
    result[39:8] == $past(x_operand[39:8])) else $error("pass changed operand");
  nan_ones_a: assert property (flt && nan_x |=> result == 40'hFF_FFFF_FFFF && alu_invalid_flag)
    else $error("nan input not all ones");
  float_clear_a: assert property (flt |=> !alu_carry_flag && !alu_input_sign_flag &&
    (alu_zero_flag || !alu_underflow_flag)) else $error("float flags wrong");
  apb_error_a: assert property (psel && penable |-> pready &&
    pslverr == !(paddr inside {12'h000, 12'h004})) else $error("apb response wrong");
  cover property (legal ##1 legal);
  cover property (flt && nan_x);
  cover property (psel && penable && pslverr);
endmodule
bind fixed_float_alu_ops alu_ops_props u_alu_ops_props (.pclk, .presetn, .psel, .penable,
  .paddr, .pready, .pslverr, .op_valid, .op_code, .x_operand, .result_valid, .result,
  .alu_zero_flag, .alu_underflow_flag, .alu_negative_flag, .alu_overflow_flag,
  .alu_carry_flag, .alu_input_sign_flag, .alu_invalid_flag);

/* File: op_sequencer.sv */
// sequencer model: presents queued ops to the alu, one per cycle
`timescale 1ns/1ps
module op_sequencer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  output logic             op_valid,
  output logic [3:0]       op_code,
  output logic [39:0]      x_operand,
  output logic [39:0]      y_operand
);
  logic [83:0] q[$];
  task automatic push(input logic [3:0] c, input logic [39:0] x, input logic [39:0] y);
    q.push_back({c, x, y});
  endtask
  // idle slots invert the operands so a stale value never matches by luck
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_valid <= 1'b0;
      op_code <= 4'h0;
      x_operand <= 40'h00_0000_0000;
      y_operand <= 40'h00_0000_0000;
    end else if (q.size() != 0) begin
      {op_code, x_operand, y_operand} <= q.pop_front();
      op_valid <= 1'b1;
    end else begin
      op_valid <= 1'b0;
      x_operand <= ~x_operand;
      y_operand <= ~y_operand;
    end
  end
endmodule

/* File: fixed_float_alu_ops_tb.sv */
// self-checking bench for the alu slice against a reference model
`timescale 1ns/1ps
module fixed_float_alu_ops_tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  wire  [31:0] prdata;
  wire         pready, pslverr, op_valid, result_valid;
  wire  [3:0]  op_code;
  wire  [39:0] x_operand, y_operand, result;
  wire  [6:0]  fl;
  int          fail_count = 0;
  int          checks = 0;
  logic        sat = 1'b0;
  logic        pend = 1'b0;
  logic [39:0] mr = 40'h00_0000_0000;
  logic [6:0]  mf = 7'h00;
  logic [46:0] fq[$];
  logic [31:0] rd;
  logic        er;
  logic [63:0] ra, rb;
  logic [31:0] ev[5] = '{32'h8000_0000, 32'h0000_0000, 32'h0000_0001, 32'h7FFF_FFFF,
                         32'hFFFF_FFFF};

  always #20 pclk = ~pclk;

  fixed_float_alu_ops u_fixed_float_alu_ops (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .op_valid, .op_code, .x_operand,
    .y_operand, .result_valid, .result, .alu_zero_flag(fl[0]), .alu_underflow_flag(fl[1]),
    .alu_negative_flag(fl[2]), .alu_overflow_flag(fl[3]), .alu_carry_flag(fl[4]),
    .alu_input_sign_flag(fl[5]), .alu_invalid_flag(fl[6]));
  op_sequencer u_op_sequencer (.pclk, .presetn, .op_valid, .op_code, .x_operand, .y_operand);

  function automatic logic [38:0] fx(input logic [3:0] c, input logic [31:0] x,
                                     input logic [31:0] y, input logic s);
    logic [31:0] a, b, r, ax, ay, u;
    logic [32:0] t;
    logic        ci, v, k;
    a = x;
    b = 32'h0000_0000;
    ci = 1'b0;
    if (c == 4'h0) b = 32'hFFFF_FFFF;
    if (c == 4'h1 || (c == 4'h2 && x[31])) begin
      a = ~x;
      ci = 1'b1;
    end
    t = {1'b0, a} + {1'b0, b} + {32'h0, ci};
    u = {1'b0, a[30:0]} + {1'b0, b[30:0]} + {31'h0, ci};
    k = c <= 4'h2 && t[32];
    v = c <= 4'h2 && (t[32] ^ u[31]);
    ax = x[31] ? -x : x;
    ay = y[31] ? -y : y;
    case (c)
      4'h3: r = x;
      4'h4: r = x & y;
      4'h5: r = x | y;
      4'h6: r = x ^ y;
      4'h7: r = ~x;
      4'h8: r = $signed(x) < $signed(y) ? x : y;
      4'h9: r = $signed(x) > $signed(y) ? x : y;
      4'hA: r = ax < ay ? x : (x[31] ? -ay : ay);
      default: r = (s && v) ? (c == 4'h0 ? 32'h8000_0000 : 32'h7FFF_FFFF) : t[31:0];
    endcase
    return {1'b0, c == 4'h2 && x[31], k, v, r[31], 1'b0, r == 32'h0, r};
  endfunction

  task automatic cmp(input logic [39:0] g, input logic [39:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // model samples the same edge the alu takes the op on
  always @(posedge pclk) begin
    pend = 1'b0;
    if (presetn && op_valid && op_code <= 4'hC) begin
      pend = 1'b1;
      if (op_code >= 4'hB) {mf, mr} = fq.pop_front();
      else {mf, mr} = {fx(op_code, x_operand[39:8], y_operand[39:8], sat), 8'h00};
    end
  end

  always @(negedge pclk) begin
    if (presetn) begin
      cmp({39'h0, result_valid}, {39'h0, pend});
      cmp(result, mr);
      cmp({33'h0, fl}, {33'h0, mf});
    end
  end

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge so a following setup never re-drives psel in this step
    @(posedge pclk);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0000_0000);
    cmp({8'h00, rd}, {8'h00, e});
    cmp({39'h0, er}, {39'h0, ee});
  endtask

  task automatic ctrl(input logic [31:0] v);
    apb(1'b1, 12'h000, v);
    sat = v[0];
  endtask

  task automatic drain();
    while (u_op_sequencer.q.size() != 0) @(posedge pclk);
    repeat (2) @(posedge pclk);
  endtask

  task automatic flt(input logic [31:0] c, input logic [3:0] o, input logic [39:0] x,
                     input logic [39:0] y, input logic [6:0] f, input logic [39:0] r);
    ctrl(c);
    fq.push_back({f, r});
    u_op_sequencer.push(o, x, y);
    drain();
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    end_sim();
  end

  initial begin
    void'($urandom(32'h3514_8c53));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(12'h000, 32'h0000_0000, 1'b0);
    rdchk(12'h004, 32'h0000_0000, 1'b0);
    ctrl(32'hFFFF_FFFF);
    rdchk(12'h000, 32'h0000_0007, 1'b0);
    apb(1'b1, 12'h004, 32'h0000_007F);
    rdchk(12'h004, 32'h0000_0000, 1'b0);
    apb(1'b1, 12'h008, 32'h0000_0001);
    cmp({39'h0, er}, 40'h00_0000_0001);
    rdchk(12'h008, 32'h0000_0000, 1'b1);
    $display("test registers done");
    for (int s = 0; s < 2; s++) begin
      ctrl({31'h0, s[0]});
      foreach (ev[i]) for (int c = 0; c < 10; c++)
        u_op_sequencer.push(c[3:0], {ev[i], 8'hA5}, {ev[4 - i], 8'h5A});
      drain();
    end
    $display("test fixed edges done");
    for (int n = 0; n < 400; n++) begin
      if (n % 100 == 0) begin
        drain();
        ctrl($urandom);
      end
      ra = {$urandom, $urandom};
      rb = {$urandom, $urandom};
      u_op_sequencer.push(n % 7 == 6 ? 4'hD : 4'($urandom % 11), ra[39:0], rb[39:0]);
    end
    drain();
    rdchk(12'h004, {25'h0, mf}, 1'b0);
    $display("test fixed random done");
    flt(0, 4'hB, 40'h3F_8000_0000, 40'h3F_8000_0000, 7'h00, 40'h40_0000_0000);
    flt(0, 4'hC, 40'h3F_8000_0000, 40'h3F_8000_0000, 7'h01, 40'h00_0000_0000);
    flt(0, 4'hB, 40'h7F_C000_0000, 40'h3F_8000_0000, 7'h40, 40'hFF_FFFF_FFFF);
    flt(0, 4'hB, 40'h7F_8000_0000, 40'hFF_8000_0000, 7'h40, 40'hFF_FFFF_FFFF);
    flt(0, 4'hC, 40'h7F_8000_0000, 40'h7F_8000_0000, 7'h40, 40'hFF_FFFF_FFFF);
    flt(0, 4'hB, 40'h00_0000_0001, 40'hBF_8000_0000, 7'h04, 40'hBF_8000_0000);
    flt(0, 4'hB, 40'h7F_7FFF_FFFF, 40'h7F_7FFF_FFFF, 7'h08, 40'h7F_8000_0000);
    flt(2, 4'hC, 40'hFF_7FFF_FFFF, 40'h7F_7FFF_FFFF, 7'h0C, 40'hFF_7FFF_FFFF);
    flt(6, 4'hB, 40'h3F_8000_00FF, 40'h00_0000_0000, 7'h00, 40'h3F_8000_0000);
    flt(4, 4'hB, 40'h3F_8000_00C0, 40'h00_0000_0000, 7'h00, 40'h3F_8000_0100);
    flt(0, 4'hB, 40'h3F_8000_0000, 40'h2F_C000_0000, 7'h00, 40'h3F_8000_0001);
    flt(0, 4'hC, 40'h00_8000_0001, 40'h00_8000_0000, 7'h03, 40'h00_0000_0000);
    rdchk(12'h004, {25'h0, mf}, 1'b0);
    $display("test float done");
    end_sim();
  end
endmodule
